// ### design/mjid_pkg.sv
// constants and types shared by the memory test access port
package mjid_pkg;
   localparam int          IR_W        = 8;
   localparam logic [7:0]  IR_EXTEST   = 8'h00;
   localparam logic [7:0]  IR_IDCODE   = 8'h21;
   localparam logic [7:0]  IR_SAMPLE   = 8'h05;
   localparam logic [7:0]  IR_CLAMP    = 8'h07;
   localparam logic [7:0]  IR_HIGHZ    = 8'h03;
   localparam logic [7:0]  IR_BYPASS   = 8'hff;
   localparam logic [7:0]  IR_CAPT_VAL = 8'h01;
   localparam int          BSR_CELLS   = 113;
   localparam int          ID_W        = 32;
   localparam int          ID_REV_LSB  = 28;
   localparam int          ID_DEV_LSB  = 12;
   localparam int          ID_VEN_LSB  = 1;
   localparam logic [1:0]  ID_DIE_REV  = 2'h0;
   localparam logic [1:0]  ID_ORG_X9   = 2'h0;
   localparam logic [1:0]  ID_ORG_X18  = 2'h1;
   // arbitrary device and vendor codes, not those of any real part
   localparam logic [15:0] ID_DEVICE   = 16'h1234;
   localparam logic [10:0] ID_VENDOR   = 11'h155;
   localparam logic        ID_PRESENT  = 1'h1;
   localparam logic        BYP_CAPT    = 1'h0;

   typedef enum logic [3:0] {
      ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
      ST_PA_DR, ST_EX2_DR, ST_UP_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
      ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UP_IR
   } mjid_tap_state_t;

   typedef enum logic [1:0] {
      SEL_BYP, SEL_ID, SEL_BSR
   } mjid_dr_sel_t;
endpackage

// ### design/mjid_tap_fsm.sv
// sixteen-state test access port controller, stepped by tms
`timescale 1ns/10ps
`default_nettype none
module mjid_tap_fsm
   import mjid_pkg::*;
(
   input  wire logic      tck,
   input  wire logic      tap_rst,
   input  wire logic      tms,
   output var mjid_tap_state_t state
);
   mjid_tap_state_t state_r;
   mjid_tap_state_t state_nxt;

   always_comb begin
      case (state_r)
         ST_TLR:    state_nxt = tms ? ST_TLR    : ST_RTI;
         ST_RTI:    state_nxt = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: state_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  state_nxt = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: state_nxt = tms ? ST_UP_DR  : ST_PA_DR;
         ST_PA_DR:  state_nxt = tms ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: state_nxt = tms ? ST_UP_DR  : ST_SH_DR;
         ST_UP_DR:  state_nxt = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: state_nxt = tms ? ST_TLR    : ST_CAP_IR;
         ST_CAP_IR: state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  state_nxt = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: state_nxt = tms ? ST_UP_IR  : ST_PA_IR;
         ST_PA_IR:  state_nxt = tms ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: state_nxt = tms ? ST_UP_IR  : ST_SH_IR;
         ST_UP_IR:  state_nxt = tms ? ST_SEL_DR : ST_RTI;
         default:   state_nxt = ST_TLR;
      endcase
   end

   always_ff @(posedge tck) begin
      if (tap_rst) begin
         state_r <= ST_TLR;
      end else begin
         state_r <= state_nxt; // R15
      end
   end

   assign state = state_r;
endmodule // mjid_tap_fsm
`default_nettype wire

// ### design/mjid_bsr.sv
// boundary scan chain: capture/shift stage and update hold stage per cell
`timescale 1ns/10ps
`default_nettype none
module mjid_bsr #(
   parameter int N = 113
) (
   input  wire logic         tck,
   input  wire logic         tap_rst,
   input  wire logic         cap,
   input  wire logic         shift,
   input  wire logic         upd,
   input  wire logic         tdi,
   input  wire logic [N-1:0] pad_in,
   output logic      [N-1:0] cells,
   output logic      [N-1:0] hold,
   output logic              so
);
   logic [N-1:0] cell_r;
   logic [N-1:0] hold_r;
   logic [N-1:0] shin;

   // cell 0 is scan position one and sits next to the serial output
   assign shin = {tdi, cell_r[N-1:1]};

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_cell
         always_ff @(posedge tck) begin
            if (tap_rst) begin
               cell_r[i] <= 1'h0;
               hold_r[i] <= 1'h0;
            end else begin
               if (cap) begin
                  cell_r[i] <= pad_in[i]; // R14
               end else if (shift) begin
                  cell_r[i] <= shin[i];
               end
               if (upd) begin
                  hold_r[i] <= cell_r[i];
               end
            end
         end
      end
   endgenerate

   assign cells = cell_r;
   assign hold  = hold_r;
   assign so    = cell_r[0];
endmodule // mjid_bsr
`default_nettype wire

// ### design/mjid_tap.sv
// instruction decode and data register selection of the memory test port
// Operation
// R1: code 00h: boundary chain in path, capture ring
// R2: code 21h: load identification word, select it
// R3: code 05h: snapshot pins into boundary chain
// R4: code 07h: bypass path, outputs from cells
// R5: code 03h: bypass path, all outputs high-z
// R6: code ffh: single bypass bit only
// R7: controller loads only the six defined codes; code loads any shifted code, undefined ones select bypass
// R8: id bits 31:28 revision, width organisation
// R9: id bits 27:12 fixed device identifier
// R10: id bits 11:1 fixed manufacturer code
// R11: id bit 0 always one
// R12: identification instruction after power-up, reset
// R13: instruction acts only after Update-IR
// R14: boundary chain has 113 cells, fixed order
// R15: standard tap states, capture and shift
`timescale 1ns/10ps
`default_nettype none
module mjid_tap
   import mjid_pkg::*;
#(
   parameter int         N_CELLS = BSR_CELLS,
   parameter logic [1:0] ID_ORG  = ID_ORG_X18
) (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               tck,
   input  wire logic               tms,
   input  wire logic               tdi,
   output logic                    tdo,
   output logic                    tdo_oe,
   input  wire logic [N_CELLS-1:0] pad_in,
   input  wire logic [N_CELLS-1:0] core_out,
   input  wire logic [N_CELLS-1:0] core_oe,
   output logic      [N_CELLS-1:0] pad_out,
   output logic      [N_CELLS-1:0] pad_oe
);
   // the capture map and scan order only exist for the full chain
   if (N_CELLS != BSR_CELLS) begin : g_bad_len
      $error("boundary chain length must be 113");
   end

   // ---------------- test clock domain ----------------
   logic                 trst_m_r;
   logic                 trst_s_r;
   logic                 tap_rst;
   logic [N_CELLS-1:0]   pad_m_r;
   logic [N_CELLS-1:0]   pad_s_r;
   mjid_tap_state_t      st;
   logic [IR_W-1:0]      ir_r;
   logic [IR_W-1:0]      ir_sh_r;
   logic [IR_W-1:0]      ir_nxt;
   logic [ID_W-1:0]      id_sh_r;
   logic                 byp_r;
   logic                 clamp_t_r;
   logic                 hiz_t_r;
   logic                 tog_t_r;
   logic                 tdo_r;
   logic                 tdo_oe_r;
   logic [N_CELLS-1:0]   bsr_cells;
   logic [N_CELLS-1:0]   bsr_hold;
   logic                 bsr_so;
   mjid_dr_sel_t         dr_sel;
   wire  logic [ID_W-1:0] id_word;
   wire  logic           in_tlr;
   wire  logic           cap_dr;
   wire  logic           sh_dr;
   wire  logic           up_dr;
   wire  logic           cap_ir;
   wire  logic           sh_ir;
   wire  logic           up_ir;
   wire  logic           bsr_cap;
   wire  logic           bsr_sh;
   wire  logic           bsr_up;
   wire  logic           clamp_nxt;
   wire  logic           hiz_nxt;
   wire  logic           mode_chg;
   wire  logic           dr_bit;

   // power-up reset reaches the test clock through two flops
   always_ff @(posedge tck) begin
      trst_m_r <= ~rst_n;
      trst_s_r <= trst_m_r;
   end
   assign tap_rst = trst_s_r;

   // ring levels come from the memory side; pass two flops first
   always_ff @(posedge tck) begin
      pad_m_r <= pad_in;
      pad_s_r <= pad_m_r;
   end

   mjid_tap_fsm u_fsm (
      .tck     (tck),
      .tap_rst (tap_rst),
      .tms     (tms),
      .state   (st)
   );

   assign in_tlr = (st == ST_TLR);
   assign cap_dr = (st == ST_CAP_DR);
   assign sh_dr  = (st == ST_SH_DR);
   assign up_dr  = (st == ST_UP_DR);
   assign cap_ir = (st == ST_CAP_IR);
   assign sh_ir  = (st == ST_SH_IR);
   assign up_ir  = (st == ST_UP_IR);

   // R8 R9 R10 R11
   assign id_word = {ID_DIE_REV, ID_ORG, ID_DEVICE, ID_VENDOR, ID_PRESENT};

   // R1 R2 R3 R4 R5 R6 R7 (reserved codes fall back to bypass)
   assign dr_sel = (ir_r == IR_EXTEST || ir_r == IR_SAMPLE) ? SEL_BSR :
                   (ir_r == IR_IDCODE)                      ? SEL_ID  :
                                                              SEL_BYP;

   assign bsr_cap = cap_dr & (dr_sel == SEL_BSR); // R1 R3
   assign bsr_sh  = sh_dr  & (dr_sel == SEL_BSR);
   assign bsr_up  = up_dr  & (dr_sel == SEL_BSR);

   mjid_bsr #(
      .N (N_CELLS)
   ) u_bsr (
      .tck     (tck),
      .tap_rst (tap_rst),
      .cap     (bsr_cap),
      .shift   (bsr_sh),
      .upd     (bsr_up),
      .tdi     (tdi),
      .pad_in  (pad_s_r),
      .cells   (bsr_cells),
      .hold    (bsr_hold),
      .so      (bsr_so)
   );

   // R12 R13: only Update-IR or test-logic-reset change the instruction
   assign ir_nxt = in_tlr ? IR_IDCODE : (up_ir ? ir_sh_r : ir_r);

   always_ff @(posedge tck) begin
      if (tap_rst) begin
         ir_r <= IR_IDCODE; // R12
      end else begin
         ir_r <= ir_nxt; // R13
      end
   end

   always_ff @(posedge tck) begin
      if (tap_rst) begin
         ir_sh_r <= IR_CAPT_VAL;
      end else if (cap_ir) begin
         ir_sh_r <= IR_CAPT_VAL; // R15
      end else if (sh_ir) begin
         ir_sh_r <= {tdi, ir_sh_r[IR_W-1:1]}; // R15
      end
   end

   always_ff @(posedge tck) begin
      if (tap_rst) begin
         id_sh_r <= '0;
      end else if (cap_dr && dr_sel == SEL_ID) begin
         id_sh_r <= id_word; // R2
      end else if (sh_dr && dr_sel == SEL_ID) begin
         id_sh_r <= {tdi, id_sh_r[ID_W-1:1]};
      end
   end

   always_ff @(posedge tck) begin
      if (tap_rst) begin
         byp_r <= BYP_CAPT;
      end else if (cap_dr && dr_sel == SEL_BYP) begin
         byp_r <= BYP_CAPT; // R6
      end else if (sh_dr && dr_sel == SEL_BYP) begin
         byp_r <= tdi; // R4 R5 R6
      end
   end

   // pin-control modes follow the active instruction only
   assign clamp_nxt = (ir_nxt == IR_CLAMP); // R4
   assign hiz_nxt   = (ir_nxt == IR_HIGHZ); // R5
   assign mode_chg  = (clamp_nxt != clamp_t_r) | (hiz_nxt != hiz_t_r);

   always_ff @(posedge tck) begin
      if (tap_rst) begin
         clamp_t_r <= 1'h0;
         hiz_t_r   <= 1'h0;
         tog_t_r   <= 1'h0;
      end else begin
         clamp_t_r <= clamp_nxt;
         hiz_t_r   <= hiz_nxt;
         tog_t_r   <= tog_t_r ^ (mode_chg | bsr_up);
      end
   end

   assign dr_bit = (dr_sel == SEL_BSR) ? bsr_so :
                   (dr_sel == SEL_ID)  ? id_sh_r[0] : byp_r;

   // serial output changes on the falling edge, as the tester expects
   always_ff @(negedge tck) begin
      if (tap_rst) begin
         tdo_r    <= 1'h0;
         tdo_oe_r <= 1'h0;
      end else begin
         tdo_r    <= sh_ir ? ir_sh_r[0] : dr_bit;
         tdo_oe_r <= sh_ir | sh_dr;
      end
   end

   assign tdo    = tdo_r;
   assign tdo_oe = tdo_oe_r;

   // ---------------- memory clock domain ----------------
   // mode bits and hold cells are static for many test clocks after a
   // toggle, so one toggle handshake carries the whole bundle
   logic               tog_m_r;
   logic               tog_s_r;
   logic               tog_d_r;
   logic               clamp_r;
   logic               hiz_r;
   logic [N_CELLS-1:0] hold_r;
   logic [N_CELLS-1:0] pad_out_r;
   logic [N_CELLS-1:0] pad_oe_r;
   wire  logic         take;
   wire  logic [N_CELLS-1:0] pad_out_nxt;
   wire  logic [N_CELLS-1:0] pad_oe_nxt;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tog_m_r <= 1'h0;
         tog_s_r <= 1'h0;
         tog_d_r <= 1'h0;
      end else begin
         tog_m_r <= tog_t_r;
         tog_s_r <= tog_m_r;
         tog_d_r <= tog_s_r;
      end
   end
   assign take = tog_s_r ^ tog_d_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clamp_r <= 1'h0;
         hiz_r   <= 1'h0;
         hold_r  <= '0;
      end else if (take) begin
         clamp_r <= clamp_t_r;
         hiz_r   <= hiz_t_r;
         hold_r  <= bsr_hold;
      end
   end

   // other instructions leave the memory pins untouched
   assign pad_out_nxt = clamp_r ? hold_r : core_out; // R4 R1 R2 R6
   assign pad_oe_nxt  = hiz_r   ? '0 :
                        clamp_r ? '1 : core_oe; // R5 R4

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pad_out_r <= '0;
         pad_oe_r  <= '0;
      end else begin
         pad_out_r <= pad_out_nxt;
         pad_oe_r  <= pad_oe_nxt;
      end
   end

   assign pad_out = pad_out_r;
   assign pad_oe  = pad_oe_r;

   // ---------------- checks ----------------
   AST_TLR_IDCODE: assert property ( // R12
      @(posedge tck) disable iff (tap_rst)
      in_tlr |=> (ir_r == IR_IDCODE))
      else $error("instruction not identification after reset state");

   AST_IR_HOLDS: assert property ( // R13
      @(posedge tck) disable iff (tap_rst)
      (!up_ir && !in_tlr) |=> $stable(ir_r))
      else $error("instruction changed outside Update-IR");

   AST_IR_LOADS: assert property ( // R13
      @(posedge tck) disable iff (tap_rst)
      up_ir |=> (ir_r == $past(ir_sh_r)))
      else $error("Update-IR did not load the shifted code");

   AST_ID_REV: assert property ( // R8
      @(posedge tck) disable iff (tap_rst)
      (cap_dr && ir_r == IR_IDCODE)
      |=> (id_sh_r[31:28] == {ID_DIE_REV, ID_ORG}))
      else $error("identification revision field wrong");

   AST_ID_DEV: assert property ( // R9
      @(posedge tck) disable iff (tap_rst)
      (cap_dr && ir_r == IR_IDCODE) |=> (id_sh_r[27:12] == ID_DEVICE))
      else $error("identification device field wrong");

   AST_ID_VEN: assert property ( // R10
      @(posedge tck) disable iff (tap_rst)
      (cap_dr && ir_r == IR_IDCODE) |=> (id_sh_r[11:1] == ID_VENDOR))
      else $error("identification vendor field wrong");

   AST_ID_LSB_ONE: assert property ( // R11
      @(posedge tck) disable iff (tap_rst)
      (cap_dr && ir_r == IR_IDCODE) |=> (id_sh_r[0] == 1'h1))
      else $error("identification bit 0 not one");

   AST_BSR_CAPTURE: assert property ( // R1 R3
      @(posedge tck) disable iff (tap_rst)
      (cap_dr && (ir_r == IR_EXTEST || ir_r == IR_SAMPLE))
      |=> (bsr_cells == $past(pad_s_r)))
      else $error("boundary chain missed the ring snapshot");

   AST_BYPASS_PATH: assert property ( // R4 R5 R6 R7
      @(posedge tck) disable iff (tap_rst)
      (sh_dr && dr_sel == SEL_BYP) ##1 sh_dr
      |-> ##0 (byp_r == $past(tdi)))
      else $error("bypass bit did not take serial input");

   AST_HIZ_OFF: assert property ( // R5
      @(posedge clk) disable iff (!rst_n)
      hiz_r |=> (pad_oe_r == '0))
      else $error("outputs enabled while high-z selected");

   AST_CLAMP_DRIVE: assert property ( // R4
      @(posedge clk) disable iff (!rst_n)
      (clamp_r && !hiz_r) |=> (pad_out_r == $past(hold_r)))
      else $error("clamped outputs not from boundary cells");

   AST_NO_DISTURB: assert property ( // R1 R2 R6
      @(posedge clk) disable iff (!rst_n)
      (rst_n && !clamp_r && !hiz_r)
      |=> (pad_out_r == $past(core_out) && pad_oe_r == $past(core_oe)))
      else $error("memory pins disturbed by a transparent mode");
endmodule // mjid_tap
`default_nettype wire

// ### tb/mjid_jtag_host.sv
// behavioural test controller that drives the link side of the test port
`timescale 1ns/10ps
`default_nettype none
module mjid_jtag_host (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   // link clock stands low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // one 48 ns link cycle: tms/tdi move while tck is low, tdo taken at rise
   task automatic step(input logic m, input logic b, output logic q);
      tms = m;
      tdi = b;
      #12;
      tck = 1'b1;
      q = tdo;
      #24;
      tck = 1'b0;
      #12;
   endtask

   // five ones reach test-logic-reset whatever the state, then idle
   task automatic reset_tap();
      logic q;
      repeat (5) step(1'b1, ~tdi, q);
      step(1'b0, ~tdi, q);
   endtask

   // from idle: capture, shift n bits lsb first, update, back to idle
   task automatic scan(input logic ir, input int n, input logic [127:0] din,
                       output logic [127:0] dout);
      logic q;
      dout = '0;
      step(1'b1, ~tdi, q);
      if (ir) begin
         step(1'b1, ~tdi, q);
      end
      step(1'b0, ~tdi, q);
      step(1'b0, ~tdi, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, ~tdi, q);
      step(1'b0, ~tdi, q);
      // released data line must not keep showing the last bit
      tdi = ~tdi;
   endtask
endmodule // mjid_jtag_host
`default_nettype wire

// ### tb/memory_jtag_instruction_decode_tb.sv
// self-checking bench of the memory test port instruction decode
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin \
   compares++; \
   if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
   end \
end
module memory_jtag_instruction_decode_tb;
   import mjid_pkg::*;
   localparam logic [127:0] PATW = {4{32'hc3a5_0f96}};
   localparam logic [112:0] PAT  = PATW[112:0];
   logic              clk;
   logic              rst_n;
   logic      [112:0] pad_in;
   logic      [112:0] core_out;
   logic      [112:0] core_oe;
   wire logic         tck;
   wire logic         tms;
   wire logic         tdi;
   wire logic         tdo;
   wire logic         tdo_oe;
   wire logic [112:0] pad_out;
   wire logic [112:0] pad_oe;
   logic      [127:0] d;
   int                error_cnt;
   int                compares;

   mjid_tap #(.N_CELLS(BSR_CELLS), .ID_ORG(ID_ORG_X18)) dut (
      .clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .core_out(core_out),
      .core_oe(core_oe), .pad_out(pad_out), .pad_oe(pad_oe)
   );
   mjid_jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic stop_test();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // pin side follows a mode change within five clk cycles
   task automatic load_ir(input logic [7:0] code);
      host.scan(1'b1, 8, {120'h0, code}, d);
      `CHK("ir capture", IR_CAPT_VAL, d[7:0])
      repeat (8) @(posedge clk);
   endtask

   task automatic t_idcode();
      host.scan(1'b0, 32, 128'h0, d);
      `CHK("id revision", {ID_DIE_REV, ID_ORG_X18}, d[31:28])
      `CHK("id device", ID_DEVICE, d[27:12])
      `CHK("id vendor", ID_VENDOR, d[11:1])
      `CHK("id bit0", 1'b1, d[0])
      `CHK("tdo_oe idle", 1'b0, tdo_oe)
   endtask

   // capture under both chain codes; last update leaves ~PAT in the cells
   task automatic t_chain();
      logic [7:0] codes [2] = '{IR_EXTEST, IR_SAMPLE};
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         pad_in <= PAT ^ {113{i[0]}};
         load_ir(codes[i]);
         `CHK("pads kept", {core_oe, core_out}, {pad_oe, pad_out})
         host.scan(1'b0, 113, {15'h0, ~PAT}, d);
         `CHK("chain", PAT ^ {113{i[0]}}, d[112:0])
      end
   endtask

   task automatic t_pins();
      load_ir(IR_CLAMP);
      `CHK("clamp out", ~PAT, pad_out)
      `CHK("clamp oe", {113{1'b1}}, pad_oe)
      load_ir(IR_HIGHZ);
      `CHK("high-z oe", {113{1'b0}}, pad_oe)
   endtask

   // one-bit path delays tdi by one and captures zero; only defined
   // codes are loaded, and ending in bypass must bring the pins back live
   task automatic t_bypass();
      logic [7:0] codes [4] = '{IR_BYPASS, IR_CLAMP, IR_HIGHZ, IR_BYPASS};
      for (int i = 0; i < 4; i++) begin
         load_ir(codes[i]);
         host.scan(1'b0, 3, 128'h3, d);
         `CHK("bypass path", 3'b110, d[2:0])
      end
      @(posedge clk);
      core_out <= ~core_out;
      repeat (4) @(posedge clk);
      `CHK("pads live", {core_oe, core_out}, {pad_oe, pad_out})
   endtask

   initial begin
      rst_n = 1'b0;
      pad_in = '0;
      core_out = PAT;
      core_oe = ~PAT;
      error_cnt = 0;
      compares = 0;
      // reset must see both clocks, so the link runs meanwhile
      fork
         repeat (12) @(posedge clk);
         host.reset_tap();
      join
      @(posedge clk);
      rst_n <= 1'b1;
      host.reset_tap();
      t_idcode();
      t_chain();
      t_pins();
      t_bypass();
      host.reset_tap();
      t_idcode();
      stop_test();
   end

   initial begin
      #200000;
      error_cnt++;
      $display("[FAIL] watchdog expected finish seen hang");
      stop_test();
   end
endmodule // memory_jtag_instruction_decode_tb
`default_nettype wire
